// File: core/imdu_defines.svh
// Constants for the integer multiply and divide unit
`ifndef IMDU_DEFINES_SVH
`define IMDU_DEFINES_SVH
`define IMDU_DIV_MIN_CYC 2
`define IMDU_DIV_MAX_CYC 11
`define IMDU_HW_BOT_LSB  0
`define IMDU_HW_TOP_LSB  16
`define IMDU_WHP_DROP    16
`define IMDU_RADIX_BITS  4
`endif

// File: core/imdu_pkg.sv
// Types for the integer multiply and divide unit
`default_nettype none
package imdu_pkg;
  typedef enum logic [4:0] {
    OP_MUL_LOW                 = 5'h00,
    OP_MUL_LOW_FLAGGED         = 5'h01,
    OP_MUL_ADD                 = 5'h02,
    OP_MUL_SUB                 = 5'h03,
    OP_DIV_SIGNED              = 5'h04,
    OP_DIV_UNSIGNED            = 5'h05,
    OP_HALFWORD_MAC_BOT_BOT    = 5'h06,
    OP_HALFWORD_MAC_BOT_TOP    = 5'h07,
    OP_HALFWORD_MAC_TOP_BOT    = 5'h08,
    OP_HALFWORD_MAC_TOP_TOP    = 5'h09,
    OP_WORD_HALFWORD_MAC_BOT   = 5'h0a,
    OP_WORD_HALFWORD_MAC_TOP   = 5'h0b,
    OP_DUAL_MAC                = 5'h0c,
    OP_DUAL_MAC_EXCHANGE       = 5'h0d,
    OP_LONG_HALFWORD_MAC_BOT_BOT = 5'h0e,
    OP_LONG_HALFWORD_MAC_BOT_TOP = 5'h0f,
    OP_LONG_HALFWORD_MAC_TOP_BOT = 5'h10,
    OP_LONG_HALFWORD_MAC_TOP_TOP = 5'h11,
    OP_LONG_DUAL_MAC           = 5'h12,
    OP_LONG_DUAL_MAC_EXCHANGE  = 5'h13
  } imdu_op_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DIV  = 2'b01,
    ST_DONE = 2'b11
  } imdu_state_type;
endpackage : imdu_pkg
`default_nettype wire

// File: core/imdu_divider.sv
// Iterative radix-16 divider, four quotient bits a cycle
`default_nettype none
`include "imdu_defines.svh"
module imdu_divider #(
  parameter int WIDTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             start,
  input  wire logic             signedDiv,
  input  wire logic [WIDTH-1:0] dividend,
  input  wire logic [WIDTH-1:0] divisor,
  output logic                  done,
  output logic      [WIDTH-1:0] quotient
);
  localparam int STEP = `IMDU_RADIX_BITS;
  localparam int CW   = $clog2(WIDTH + 1);
  logic [WIDTH-1:0] quo_r;
  logic [WIDTH-1:0] rem_r;
  logic [WIDTH-1:0] den_r;
  logic [CW-1:0]    left_r;
  logic             negQ_r;
  logic             busy_r;
  logic [WIDTH-1:0] absN;
  logic [WIDTH-1:0] absD;
  logic [WIDTH-1:0] q_nxt;
  logic [WIDTH-1:0] r_nxt;
  logic [CW-1:0]    lead;
  logic [WIDTH:0]   trial;

  assign absN = (signedDiv && dividend[WIDTH-1]) ? -dividend : dividend;
  assign absD = (signedDiv && divisor[WIDTH-1]) ? -divisor : divisor;

  // Skip leading zero nibbles so small nonzero dividends finish early
  always_comb begin
    lead = CW'(WIDTH);
    for (int i = 0; i < WIDTH; i++) begin
      if (absN[i]) begin
        lead = CW'(i + 1);
      end
    end
    lead = CW'(((int'(lead) + STEP - 1) / STEP) * STEP);
  end

  always_comb begin
    q_nxt = quo_r;
    r_nxt = rem_r;
    trial = '0;
    for (int i = 0; i < STEP; i++) begin
      trial = {r_nxt, q_nxt[WIDTH-1]} - {1'b0, den_r};
      if (!trial[WIDTH]) begin
        r_nxt = trial[WIDTH-1:0];
        q_nxt = {q_nxt[WIDTH-2:0], 1'b1};
      end else begin
        r_nxt = {r_nxt[WIDTH-2:0], q_nxt[WIDTH-1]};
        q_nxt = {q_nxt[WIDTH-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      done   <= 1'b0;
      quo_r  <= '0;
      rem_r  <= '0;
      den_r  <= '0;
      left_r <= '0;
      negQ_r <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy_r <= 1'b1;
        // Align the dividend so the first nibble holds its top bits
        quo_r  <= absN << (CW'(WIDTH) - lead);
        rem_r  <= '0;
        den_r  <= absD;
        left_r <= lead;
        negQ_r <= signedDiv && (dividend[WIDTH-1] ^ divisor[WIDTH-1]);
      end else if (busy_r) begin
        quo_r  <= q_nxt;
        rem_r  <= r_nxt;
        left_r <= left_r - CW'(STEP);
        if (left_r <= CW'(STEP)) begin
          busy_r <= 1'b0;
          done   <= 1'b1;
        end
      end
    end
  end

  // Truncating magnitude then sign fix gives rounding toward zero
  assign quotient = (den_r == '0) ? '0 : (negQ_r ? -quo_r : quo_r);
endmodule : imdu_divider
`default_nettype wire

// File: core/imdu_unit.sv
// Integer multiply, multiply-accumulate and divide datapath
`default_nettype none
`include "imdu_defines.svh"
module imdu_unit #(
  parameter int WIDTH = 32,
  parameter int REGW  = 4
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              issueValid,
  input  wire imdu_pkg::imdu_op_type issueOp,
  input  wire logic              condPass,
  input  wire logic              destGiven,
  input  wire logic [REGW-1:0]   destReg,
  input  wire logic [REGW-1:0]   firstReg,
  input  wire logic [REGW-1:0]   accumHighReg,
  input  wire logic [WIDTH-1:0]  firstOperand,
  input  wire logic [WIDTH-1:0]  secondOperand,
  input  wire logic [WIDTH-1:0]  accumOperand,
  input  wire logic [WIDTH-1:0]  accumLowIn,
  input  wire logic [WIDTH-1:0]  accumHighIn,
  input  wire logic              satClear,
  output logic                   busy,
  output logic                   resValid,
  output logic                   resLongValid,
  output logic [REGW-1:0]        resLowReg,
  output logic [REGW-1:0]        resHighReg,
  output logic [WIDTH-1:0]       resLow,
  output logic [WIDTH-1:0]       resHigh,
  output logic                   flagNZValid,
  output logic                   flagNeg,
  output logic                   flagZero,
  output logic                   satFlag
);
  localparam int HW = WIDTH / 2;
  localparam int LW = 2 * WIDTH;

  imdu_pkg::imdu_state_type state_r;
  logic [REGW-1:0] divReg_r;
  logic            divStart;
  logic            divDone;
  logic [WIDTH-1:0] divQuot;

  // Halfword selects
  logic signed [HW-1:0] nBot, nTop, mBot, mTop, nSel, mSel;
  logic signed [WIDTH-1:0] hwProd, dualP1, dualP2;
  logic signed [WIDTH+HW-1:0] whProd;
  logic [LW-1:0]   fullProd;
  logic [WIDTH-1:0] lowRes;
  logic signed [WIDTH+1:0] wideSum;
  logic signed [LW-1:0] longSum;
  logic            isLong;
  logic            ovf;
  logic            takes;

  assign nBot = firstOperand[`IMDU_HW_BOT_LSB +: HW];
  assign nTop = firstOperand[`IMDU_HW_TOP_LSB +: HW];
  assign mBot = secondOperand[`IMDU_HW_BOT_LSB +: HW];
  assign mTop = secondOperand[`IMDU_HW_TOP_LSB +: HW];

  // Unsigned product: its low word equals the signed one's
  assign fullProd = firstOperand * secondOperand;

  always_comb begin
    nSel = nBot;
    mSel = mBot;
    unique case (issueOp)
      imdu_pkg::OP_HALFWORD_MAC_BOT_TOP,
      imdu_pkg::OP_LONG_HALFWORD_MAC_BOT_TOP: mSel = mTop;
      imdu_pkg::OP_HALFWORD_MAC_TOP_BOT,
      imdu_pkg::OP_LONG_HALFWORD_MAC_TOP_BOT: nSel = nTop;
      imdu_pkg::OP_HALFWORD_MAC_TOP_TOP,
      imdu_pkg::OP_LONG_HALFWORD_MAC_TOP_TOP: begin
        nSel = nTop;
        mSel = mTop;
      end
      imdu_pkg::OP_WORD_HALFWORD_MAC_TOP: mSel = mTop;
      default: ;
    endcase
  end

  assign hwProd = nSel * mSel;
  assign whProd = $signed(firstOperand) * mSel;

  // Exchange variants cross the second operand's halves
  always_comb begin
    if (issueOp == imdu_pkg::OP_DUAL_MAC_EXCHANGE ||
        issueOp == imdu_pkg::OP_LONG_DUAL_MAC_EXCHANGE) begin
      dualP1 = nTop * mBot;
      dualP2 = nBot * mTop;
    end else begin
      dualP1 = nTop * mTop;
      dualP2 = nBot * mBot;
    end
  end

  always_comb begin
    lowRes  = '0;
    wideSum = '0;
    longSum = '0;
    isLong  = 1'b0;
    ovf     = 1'b0;
    unique case (issueOp)
      imdu_pkg::OP_MUL_LOW,
      imdu_pkg::OP_MUL_LOW_FLAGGED: lowRes = fullProd[WIDTH-1:0];
      imdu_pkg::OP_MUL_ADD:
        lowRes = fullProd[WIDTH-1:0] + accumOperand;
      imdu_pkg::OP_MUL_SUB:
        lowRes = accumOperand - fullProd[WIDTH-1:0];
      imdu_pkg::OP_HALFWORD_MAC_BOT_BOT,
      imdu_pkg::OP_HALFWORD_MAC_BOT_TOP,
      imdu_pkg::OP_HALFWORD_MAC_TOP_BOT,
      imdu_pkg::OP_HALFWORD_MAC_TOP_TOP: begin
        wideSum = (WIDTH+2)'(hwProd) + (WIDTH+2)'($signed(accumOperand));
        lowRes  = wideSum[WIDTH-1:0];
        // Overflow also reaches the saturation flag here
        ovf     = wideSum[WIDTH] != wideSum[WIDTH-1];
      end
      imdu_pkg::OP_WORD_HALFWORD_MAC_BOT,
      imdu_pkg::OP_WORD_HALFWORD_MAC_TOP: begin
        wideSum = (WIDTH+2)'($signed(whProd[`IMDU_WHP_DROP +: WIDTH]))
                + (WIDTH+2)'($signed(accumOperand));
        lowRes  = wideSum[WIDTH-1:0];
        ovf     = wideSum[WIDTH] != wideSum[WIDTH-1];
      end
      imdu_pkg::OP_DUAL_MAC,
      imdu_pkg::OP_DUAL_MAC_EXCHANGE: begin
        wideSum = (WIDTH+2)'(dualP1) + (WIDTH+2)'(dualP2)
                + (WIDTH+2)'($signed(accumOperand));
        lowRes  = wideSum[WIDTH-1:0];
        // Any sum outside 32-bit signed range counts as overflow
        ovf     = (wideSum[WIDTH+1] != wideSum[WIDTH-1]) ||
                  (wideSum[WIDTH] != wideSum[WIDTH-1]);
      end
      imdu_pkg::OP_LONG_HALFWORD_MAC_BOT_BOT,
      imdu_pkg::OP_LONG_HALFWORD_MAC_BOT_TOP,
      imdu_pkg::OP_LONG_HALFWORD_MAC_TOP_BOT,
      imdu_pkg::OP_LONG_HALFWORD_MAC_TOP_TOP: begin
        isLong  = 1'b1;
        longSum = LW'(hwProd) + $signed({accumHighIn, accumLowIn});
      end
      imdu_pkg::OP_LONG_DUAL_MAC,
      imdu_pkg::OP_LONG_DUAL_MAC_EXCHANGE: begin
        isLong  = 1'b1;
        longSum = LW'(dualP1) + LW'(dualP2)
                + $signed({accumHighIn, accumLowIn});
      end
      default: ;
    endcase
  end

  // Issuer keeps stack pointer, program counter and pair aliasing out
  assign takes    = issueValid && condPass && state_r == imdu_pkg::ST_IDLE;
  assign divStart = takes && (issueOp == imdu_pkg::OP_DIV_SIGNED ||
                              issueOp == imdu_pkg::OP_DIV_UNSIGNED);

  imdu_divider #(
    .WIDTH (WIDTH)
  ) u_div (
    .clk       (clk),
    .rst_n     (rst_n),
    .start     (divStart),
    .signedDiv (issueOp == imdu_pkg::OP_DIV_SIGNED),
    .dividend  (firstOperand),
    .divisor   (secondOperand),
    .done      (divDone),
    .quotient  (divQuot)
  );

  // Divider holds the pipeline for its variable latency
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r  <= imdu_pkg::ST_IDLE;
      divReg_r <= '0;
      busy     <= 1'b0;
    end else begin
      unique case (state_r)
        imdu_pkg::ST_IDLE: if (divStart) begin
          state_r  <= imdu_pkg::ST_DIV;
          divReg_r <= destGiven ? destReg : firstReg;
          busy     <= 1'b1;
        end
        imdu_pkg::ST_DIV: if (divDone) begin
          state_r <= imdu_pkg::ST_DONE;
        end
        imdu_pkg::ST_DONE: begin
          state_r <= imdu_pkg::ST_IDLE;
          busy    <= 1'b0;
        end
        default: state_r <= imdu_pkg::ST_IDLE;
      endcase
    end
  end

  // Result write port
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      resValid     <= 1'b0;
      resLongValid <= 1'b0;
      resLowReg    <= '0;
      resHighReg   <= '0;
      resLow       <= '0;
      resHigh      <= '0;
    end else begin
      resValid     <= 1'b0;
      resLongValid <= 1'b0;
      if (state_r == imdu_pkg::ST_DIV && divDone) begin
        resValid  <= 1'b1;
        resLowReg <= divReg_r;
        resLow    <= divQuot;
      end else if (takes && !divStart) begin
        resValid     <= 1'b1;
        resLongValid <= isLong;
        if (isLong) begin
          resLowReg  <= destReg;
          resHighReg <= accumHighReg;
          resLow     <= longSum[WIDTH-1:0];
          resHigh    <= longSum[LW-1:WIDTH];
        end else begin
          resLowReg <= (destGiven || issueOp == imdu_pkg::OP_MUL_ADD ||
                        issueOp == imdu_pkg::OP_MUL_SUB) ? destReg
                                                          : firstReg;
          resLow    <= lowRes;
        end
      end
    end
  end

  // Flags: division and failed conditions never reach here
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flagNZValid <= 1'b0;
      flagNeg     <= 1'b0;
      flagZero    <= 1'b0;
    end else begin
      flagNZValid <= 1'b0;
      if (takes && issueOp == imdu_pkg::OP_MUL_LOW_FLAGGED) begin
        flagNZValid <= 1'b1;
        flagNeg     <= lowRes[WIDTH-1];
        flagZero    <= lowRes == '0;
      end
    end
  end

  // Sticky: a set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      satFlag <= 1'b0;
    end else if (takes && ovf) begin
      satFlag <= 1'b1;
    end else if (satClear) begin
      satFlag <= 1'b0;
    end
  end
endmodule : imdu_unit
`default_nettype wire

// File: bench/imdu_checker.sv
// Port assertions for the multiply and divide unit
`default_nettype none
module imdu_checker #(
  parameter int WIDTH = 32,
  parameter int REGW  = 4
) (
  input wire logic                   clk,
  input wire logic                   rst_n,
  input wire logic                   issueValid,
  input wire imdu_pkg::imdu_op_type  issueOp,
  input wire logic                   condPass,
  input wire logic                   destGiven,
  input wire logic [REGW-1:0]        firstReg,
  input wire logic [REGW-1:0]        accumHighReg,
  input wire logic [WIDTH-1:0]       firstOperand,
  input wire logic [WIDTH-1:0]       secondOperand,
  input wire logic                   satClear,
  input wire logic                   busy,
  input wire logic                   resValid,
  input wire logic                   resLongValid,
  input wire logic [REGW-1:0]        resLowReg,
  input wire logic [REGW-1:0]        resHighReg,
  input wire logic [WIDTH-1:0]       resLow,
  input wire logic                   flagNZValid,
  input wire logic                   flagNeg,
  input wire logic                   flagZero,
  input wire logic                   satFlag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic tk, dv, lg, ml;
  assign tk = issueValid && condPass && !busy;
  assign dv = issueOp inside {imdu_pkg::OP_DIV_SIGNED,
                              imdu_pkg::OP_DIV_UNSIGNED};
  assign lg = issueOp >= imdu_pkg::OP_LONG_HALFWORD_MAC_BOT_BOT;
  assign ml = issueOp inside {imdu_pkg::OP_MUL_LOW,
                              imdu_pkg::OP_MUL_LOW_FLAGGED};
  a_nondiv_next: assert property (tk && !dv |=> resValid)
    else $error("result missing one cycle after issue");
  a_mul_value: assert property (
    tk && issueOp == imdu_pkg::OP_MUL_LOW
    |=> resLow == $past(firstOperand * secondOperand))
    else $error("low product wrong");
  a_div_latency: assert property (
    tk && dv |=> !resValid ##[1:10] resValid)
    else $error("divide latency out of range");
  a_div_noflag: assert property (busy |-> !flagNZValid)
    else $error("flags written during divide");
  a_flag_cause: assert property (
    flagNZValid |-> $past(tk)
    && $past(issueOp) == imdu_pkg::OP_MUL_LOW_FLAGGED)
    else $error("flags written by wrong operation");
  a_flag_value: assert property (
    flagNZValid |-> flagZero == (resLow == '0)
    && flagNeg == resLow[WIDTH-1])
    else $error("negative or zero flag wrong");
  a_cond_quiet: assert property (
    issueValid && !condPass && !busy |=> !resValid && !flagNZValid)
    else $error("failed condition wrote state");
  a_dest_default: assert property (
    tk && ml && !destGiven |=> resLowReg == $past(firstReg))
    else $error("default destination wrong");
  a_long_pair: assert property (
    tk && lg |=> resLongValid && resHighReg == $past(accumHighReg))
    else $error("long result pair wrong");
  a_sat_sticky: assert property (
    satFlag && !satClear |=> satFlag)
    else $error("saturation flag dropped");
  c_div: cover property (tk && dv);
  c_long: cover property (tk && lg);
  c_sat: cover property ($rose(satFlag));
endmodule : imdu_checker
bind imdu_unit imdu_checker #(.WIDTH(WIDTH), .REGW(REGW)) imdu_checker_inst (
  .clk, .rst_n, .issueValid, .issueOp, .condPass, .destGiven, .firstReg,
  .accumHighReg, .firstOperand, .secondOperand, .satClear, .busy, .resValid,
  .resLongValid, .resLowReg, .resHighReg, .resLow, .flagNZValid, .flagNeg,
  .flagZero, .satFlag
);
`default_nettype wire

// File: bench/imdu_regfile_model.sv
// Register file model behind the unit's write-back port
`default_nettype none
module imdu_regfile_model (
  input wire logic        clk,
  input wire logic        resValid,
  input wire logic        resLongValid,
  input wire logic [3:0]  resLowReg,
  input wire logic [3:0]  resHighReg,
  input wire logic [31:0] resLow,
  input wire logic [31:0] resHigh
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] regs [16];
  // Halves land in separate registers of the pair
  always_ff @(posedge clk) begin
    if (resValid) regs[resLowReg] <= resLow;
    if (resLongValid) regs[resHighReg] <= resHigh;
  end
endmodule : imdu_regfile_model
`default_nettype wire

// File: bench/imdu_unit_bench.sv
// Self-checking bench for the multiply and divide unit
`default_nettype none
module imdu_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, issueValid = 1'b0, condPass = 1'b1;
  logic destGiven = 1'b1, satClear = 1'b0, cp = 1'b1, dg = 1'b1;
  imdu_pkg::imdu_op_type issueOp = imdu_pkg::OP_MUL_LOW;
  // Low registers only, no stack pointer or program counter, pair distinct
  logic [3:0]  destReg = 4'h1, firstReg = 4'h2, accumHighReg = 4'h4;
  logic [31:0] firstOperand = 32'h0, secondOperand = 32'h0;
  logic [31:0] accumOperand = 32'h0, accumLowIn = 32'hffffffff;
  logic [31:0] accumHighIn = 32'h0, resLow, resHigh;
  logic [3:0]  resLowReg, resHighReg;
  logic        busy, resValid, resLongValid, flagNZValid;
  logic        flagNeg, flagZero, satFlag;
  int          failures = 0, n_tests = 0, cyc = 0;
  logic [63:0] ex [14] = '{64'h1e, 64'h6, 64'hfffffffb, 64'h1f,
    64'hfffffff4, 64'h23, 64'h2d, 64'hfffffff1, 64'h10000000d,
    64'hfffffff5, 64'hffffffea, 64'h10000000e, 64'h10000001c, 64'hffffffe0};
  imdu_unit imdu_unit_inst (.clk, .rst_n, .issueValid, .issueOp, .condPass,
    .destGiven, .destReg, .firstReg, .accumHighReg, .firstOperand,
    .secondOperand, .accumOperand, .accumLowIn, .accumHighIn, .satClear,
    .busy, .resValid, .resLongValid, .resLowReg, .resHighReg, .resLow,
    .resHigh, .flagNZValid, .flagNeg, .flagZero, .satFlag);
  imdu_regfile_model imdu_regfile_model_inst (.clk, .resValid,
    .resLongValid, .resLowReg, .resHighReg, .resLow, .resHigh);
  always #5 clk = ~clk;
  task wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      wrap_up;
    end
  end
  task cmp(input logic [63:0] g, input logic [63:0] x);
    n_tests++;
    if (g !== x) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask : cmp
  // One issue, then a bounded wait for its result
  task automatic t(input logic [4:0] op, input logic [31:0] a, b, c,
                   input logic [63:0] e);
    int n;
    do @(posedge clk); while (busy !== 1'b0);
    issueOp <= imdu_pkg::imdu_op_type'(op);
    firstOperand <= a;
    secondOperand <= b;
    accumOperand <= c;
    condPass <= cp;
    destGiven <= dg;
    issueValid <= 1'b1;
    @(posedge clk);
    issueValid <= 1'b0;
    #1;
    if (!cp) begin
      cmp(resValid, 64'h0);
      return;
    end
    n = 1;
    while (resValid !== 1'b1 && n < 12) begin
      @(posedge clk);
      #1;
      n++;
    end
    cmp(resLow, e[31:0]);
    if (op >= 5'h0e) cmp({resLongValid, resHigh}, {1'b1, e[63:32]});
    if (op == 5'h04 || op == 5'h05) cmp(n >= 2 && n <= 11, 64'h1);
    else cmp(n, 64'h1);
  endtask : t
  task clr;
    @(posedge clk);
    satClear <= 1'b1;
    @(posedge clk);
    satClear <= 1'b0;
    #1;
    cmp(satFlag, 64'h0);
  endtask : clr
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t(5'h00, 32'hffffffff, 32'h3, 32'h0, 64'hfffffffd);
    t(5'h02, 32'h10000, 32'h10000, 32'h5, 64'h5);
    t(5'h03, 32'h3, 32'h4, 32'ha, 64'hfffffffe);
    t(5'h01, 32'h10000, 32'h10000, 32'h0, 64'h0);
    cmp({flagNeg, flagZero}, 64'h1);
    t(5'h01, 32'hffffffff, 32'h1, 32'h0, 64'hffffffff);
    t(5'h02, 32'h2, 32'h3, 32'h0, 64'h6);
    cmp({flagNeg, flagZero}, 64'h2);
    t(5'h04, 32'hfffffff9, 32'h2, 32'h0, 64'hfffffffd);
    t(5'h05, 32'hfffffff9, 32'h2, 32'h0, 64'h7ffffffc);
    t(5'h05, 32'hffffffff, 32'h1, 32'h0, 64'hffffffff);
    cmp({flagNeg, flagZero}, 64'h2);
    cp = 1'b0;
    t(5'h00, 32'h5, 32'h5, 32'h0, 64'h0);
    cp = 1'b1;
    dg = 1'b0;
    t(5'h00, 32'h6, 32'h7, 32'h0, 64'h2a);
    t(5'h04, 32'h64, 32'hfffffffb, 32'h0, 64'hffffffec);
    dg = 1'b1;
    // Register file takes the write one edge after the result pulse
    @(posedge clk);
    #1;
    cmp(imdu_regfile_model_inst.regs[2], 64'hffffffec);
    for (int i = 6; i < 14; i++) begin
      t(5'(i), 32'h0003fffe, 32'h0005fff9, 32'h10, ex[i-6]);
    end
    for (int i = 14; i < 20; i++) begin
      t(5'(i), 32'h0003fffe, 32'h0005fff9, 32'h10, ex[i-6]);
    end
    @(posedge clk);
    #1;
    cmp(imdu_regfile_model_inst.regs[1], 64'hffffffe0);
    cmp(imdu_regfile_model_inst.regs[4], 64'h0);
    cmp(satFlag, 64'h0);
    t(5'h0a, 32'h7fffffff, 32'h7fff, 32'h7fffffff, 64'hbfff7ffe);
    cmp(satFlag, 64'h1);
    t(5'h00, 32'h2, 32'h2, 32'h0, 64'h4);
    cmp(satFlag, 64'h1);
    for (int i = 12; i < 14; i++) begin
      clr;
      t(5'(i), 32'h7fff7fff, 32'h7fff7fff, 32'h7fffffff, 64'hfffe0001);
      cmp(satFlag, 64'h1);
    end
    wrap_up;
  end
endmodule : imdu_unit_bench
`default_nettype wire
